// [shared/lcfd_pkg.sv]
`default_nettype none
package lcfd_pkg;
   // Frame identifiers
   localparam logic [7:0] LCFD_ID_DIAG_REQ   = 8'h3c;
   localparam logic [7:0] LCFD_ID_DIAG_RESP  = 8'h7d;
   // Node addressing
   localparam logic [7:0] LCFD_NAD_BROADCAST = 8'h7f;
   // Parameter writing frame commands
   localparam logic [7:0] LCFD_CMD_DUAL_TARGET_MOVE      = 8'h08;
   localparam logic [7:0] LCFD_CMD_MOTOR_PARAMETER_WRITE = 8'h09;
   localparam logic [7:0] LCFD_CMD_OTP_BYTE_PROGRAM      = 8'h10;
   localparam logic [7:0] LCFD_CMD_STALL_PARAMETER_WRITE = 8'h16;
   localparam logic [7:0] LCFD_CMD_MOVE_WITH_PARAMETERS  = 8'h2f;
   // Short command frame commands
   localparam logic [7:0] LCFD_CMD_DRIVE_TO_SAFE_POSITION = 8'h04;
   localparam logic [7:0] LCFD_CMD_IMMEDIATE_STOP         = 8'h05;
   localparam logic [7:0] LCFD_CMD_ZERO_ACTUAL_POSITION   = 8'h06;
   localparam logic [7:0] LCFD_CMD_DECELERATING_STOP      = 8'h0f;
   // Diagnostic service bytes
   localparam logic [7:0] LCFD_PCI_REQ       = 8'h06;
   localparam logic [7:0] LCFD_PCI_POS       = 8'h06;
   localparam logic [7:0] LCFD_PCI_NEG       = 8'h03;
   localparam logic [7:0] LCFD_SID_READ_ID   = 8'hb2;
   localparam logic [7:0] LCFD_RSID_READ_ID  = 8'hf2;
   localparam logic [7:0] LCFD_RSID_NEG      = 8'h7f;
   localparam logic [7:0] LCFD_ERR_SUBFUNC   = 8'h12;
   localparam logic [7:0] LCFD_FILL          = 8'hff;
   localparam logic [7:0] LCFD_SEL_PRODUCT   = 8'h00;
   localparam logic [15:0] LCFD_SUPPLIER_WILD = 16'h7fff;
   localparam logic [15:0] LCFD_FUNCTION_WILD = 16'hffff;
   // Frame byte counts (data bytes, checksum excluded)
   localparam logic [3:0] LCFD_LEN_PARAM   = 4'h7;
   localparam logic [3:0] LCFD_LEN_ADDR_SC = 4'h2;
   localparam logic [3:0] LCFD_LEN_UNADDR  = 4'h1;
   localparam logic [3:0] LCFD_LEN_DIAG    = 4'h8;
   localparam logic [2:0] LCFD_PARAM_DATA  = 3'h5;
   localparam logic [4:0] LCFD_READ_WAIT   = 5'h1f;  // Cycles before a silent node is given up
   // Reset values
   localparam logic [7:0] LCFD_RST_BYTE    = 8'h00;
   localparam logic [3:0] LCFD_RST_IDX     = 4'h0;

   // Frame classes seen by the decoder
   typedef enum logic [2:0] {
      LCFD_FRM_NONE,
      LCFD_FRM_PARAM,
      LCFD_FRM_ADDR_SC,
      LCFD_FRM_UNADDR_SC,
      LCFD_FRM_DIAG_REQ,
      LCFD_FRM_DIAG_RESP
   } lcfd_frame_type;

   // Commands handed to the motion logic
   typedef enum logic [3:0] {
      LCFD_OP_NONE,
      LCFD_OP_DUAL_TARGET_MOVE,
      LCFD_OP_MOTOR_PARAMETER_WRITE,
      LCFD_OP_OTP_BYTE_PROGRAM,
      LCFD_OP_STALL_PARAMETER_WRITE,
      LCFD_OP_MOVE_WITH_PARAMETERS,
      LCFD_OP_DRIVE_TO_SAFE_POSITION,
      LCFD_OP_IMMEDIATE_STOP,
      LCFD_OP_ZERO_ACTUAL_POSITION,
      LCFD_OP_DECELERATING_STOP
   } lcfd_op_type;

   // Enhanced checksum covers the identifier, classic does not
   function automatic logic [7:0] lcfd_csum_add(input logic [7:0] acc, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, acc} + {1'b0, b};
      lcfd_csum_add = s[7:0] + {7'h00, s[8]};
   endfunction : lcfd_csum_add
endpackage : lcfd_pkg
`default_nettype wire

// [shared/lcfd_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Byte-level LIN frame channel between master controller and node decoder
interface lcfd_link_if;
   import lcfd_pkg::*;
   logic [7:0] hdr_id;     // Frame identifier, master header
   logic       hdr_valid;  // Header pulse, starts a frame
   logic [7:0] m_byte;     // Master-published byte
   logic       m_valid;    // Master byte pulse
   logic [7:0] s_byte;     // Node-published response byte
   logic       s_valid;    // Node byte pulse
   logic       eof;        // End of frame pulse from master

   modport master (output hdr_id, output hdr_valid, output m_byte, output m_valid,
                   output eof, input s_byte, input s_valid);
   modport node   (input hdr_id, input hdr_valid, input m_byte, input m_valid,
                   input eof, output s_byte, output s_valid);
endinterface : lcfd_link_if
`default_nettype wire

// [verilog/lcfd_node.sv]
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Parameter frame commands 08,09,10,16,2F
// - Master pads unused data with FF
// - Parameter frame: address, command, five data, checksum
// - Act only on own or broadcast address
// - Broadcast frames executed by every subscriber
// - Addressed short frame: address, command, checksum
// - Short commands 04,05,06,0F
// - Unaddressed short frame: command, checksum
// - Identification request layout from master
// - Only selector zero gives identification
// - Supplier 7FFF, function FFFF are wildcards
// - Answer in next reading frame
// - Positive answer layout with classic checksum
// - Answer carries own node address
// - Nonzero selector gives negative answer; the node gives no answer for selector FF
module lcfd_node
   import lcfd_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   // Node identity
   input  wire logic [7:0] i_node_addr,
   input  wire logic [7:0] i_param_frame_id,
   input  wire logic [7:0] i_addr_sc_frame_id,
   input  wire logic [7:0] i_unaddr_sc_frame_id,
   // Command output
   output logic            o_cmd_valid,
   output lcfd_op_type     o_cmd_op,
   output logic [39:0]     o_cmd_data,
   output logic            o_cmd_broadcast,
   // Link
   lcfd_link_if.node       link
);
   // Identity values, arbitrary
   localparam logic [15:0] SUPPLIER_CODE = 16'h0a5a;
   localparam logic [15:0] FUNCTION_CODE = 16'h0b6b;
   localparam logic [7:0]  VARIANT_CODE  = 8'h01;

   typedef enum logic [1:0] {LCFD_RESP_NONE, LCFD_RESP_POS, LCFD_RESP_NEG} lcfd_resp_type;

   typedef struct packed {
      lcfd_frame_type frame;
      logic [3:0]     idx;
      logic [7:0]     csum;
      logic [7:0]     nad;
      logic [7:0]     cmd;
      logic [39:0]    data;     // Data bytes 1..5 of a parameter frame
      logic [7:0]     sel;
      logic [31:0]    ids;      // Supplier then function, low byte first
      logic           csum_ok;
      lcfd_resp_type  pend;     // Prepared answer for next reading frame
      lcfd_resp_type  sending;
      logic [3:0]     tx_idx;
      logic [7:0]     tx_csum;
      logic           cmd_valid;
      lcfd_op_type    cmd_op;
      logic [39:0]    cmd_data;
      logic           cmd_bc;
      logic [7:0]     s_byte;
      logic           s_valid;
   } lcfd_state_type;

   lcfd_state_type st_reg;
   lcfd_state_type st_next;

   // Which op a parameter or short command code maps to
   function automatic lcfd_op_type lcfd_decode(input lcfd_frame_type f, input logic [7:0] c);
      lcfd_decode = LCFD_OP_NONE;
      if (f == LCFD_FRM_PARAM) begin
         unique case (c)
            LCFD_CMD_DUAL_TARGET_MOVE:      lcfd_decode = LCFD_OP_DUAL_TARGET_MOVE;
            LCFD_CMD_MOTOR_PARAMETER_WRITE: lcfd_decode = LCFD_OP_MOTOR_PARAMETER_WRITE;
            LCFD_CMD_OTP_BYTE_PROGRAM:      lcfd_decode = LCFD_OP_OTP_BYTE_PROGRAM;
            LCFD_CMD_STALL_PARAMETER_WRITE: lcfd_decode = LCFD_OP_STALL_PARAMETER_WRITE;
            LCFD_CMD_MOVE_WITH_PARAMETERS:  lcfd_decode = LCFD_OP_MOVE_WITH_PARAMETERS;
            default:                        lcfd_decode = LCFD_OP_NONE;
         endcase
      end else begin
         unique case (c)
            LCFD_CMD_DRIVE_TO_SAFE_POSITION: lcfd_decode = LCFD_OP_DRIVE_TO_SAFE_POSITION;
            LCFD_CMD_IMMEDIATE_STOP:         lcfd_decode = LCFD_OP_IMMEDIATE_STOP;
            LCFD_CMD_ZERO_ACTUAL_POSITION:   lcfd_decode = LCFD_OP_ZERO_ACTUAL_POSITION;
            LCFD_CMD_DECELERATING_STOP:      lcfd_decode = LCFD_OP_DECELERATING_STOP;
            default:                         lcfd_decode = LCFD_OP_NONE;
         endcase
      end
   endfunction : lcfd_decode

   // Data bytes a frame class expects before the checksum
   function automatic logic [3:0] lcfd_len(input lcfd_frame_type f);
      unique case (f)
         LCFD_FRM_PARAM:     lcfd_len = LCFD_LEN_PARAM;
         LCFD_FRM_ADDR_SC:   lcfd_len = LCFD_LEN_ADDR_SC;
         LCFD_FRM_UNADDR_SC: lcfd_len = LCFD_LEN_UNADDR;
         LCFD_FRM_DIAG_REQ:  lcfd_len = LCFD_LEN_DIAG;
         default:            lcfd_len = LCFD_LEN_DIAG;
      endcase
   endfunction : lcfd_len

   // Answer byte n (0..7) for the prepared answer
   function automatic logic [7:0] lcfd_tx(input lcfd_resp_type r, input logic [3:0] n,
                                          input logic [7:0] nad);
      logic [7:0] b;
      b = LCFD_FILL;
      if (r == LCFD_RESP_POS) begin
         unique case (n)
            4'h0:    b = nad;
            4'h1:    b = LCFD_PCI_POS;
            4'h2:    b = LCFD_RSID_READ_ID;
            4'h3:    b = SUPPLIER_CODE[7:0];
            4'h4:    b = SUPPLIER_CODE[15:8];
            4'h5:    b = FUNCTION_CODE[7:0];
            4'h6:    b = FUNCTION_CODE[15:8];
            default: b = VARIANT_CODE;
         endcase
      end else begin
         unique case (n)
            4'h0:    b = nad;
            4'h1:    b = LCFD_PCI_NEG;
            4'h2:    b = LCFD_RSID_NEG;
            4'h3:    b = LCFD_SID_READ_ID;
            4'h4:    b = LCFD_ERR_SUBFUNC;
            default: b = LCFD_FILL;
         endcase
      end
      lcfd_tx = b;
   endfunction : lcfd_tx

   ////////////////////////////////////////////////////////////////////////////
   // Frame decode and answer sequencing
   always_comb begin
      logic        addr_ok;
      logic        id_ok;
      lcfd_op_type op;
      addr_ok = 1'b0;
      id_ok   = 1'b0;
      op      = LCFD_OP_NONE;
      st_next = st_reg;
      st_next.cmd_valid = 1'b0;
      st_next.s_valid   = 1'b0;

      // Header: classify; a reading 0x7d header releases any prepared answer
      if (link.hdr_valid) begin
         st_next.idx     = LCFD_RST_IDX;
         st_next.sending = LCFD_RESP_NONE;
         st_next.tx_idx  = LCFD_RST_IDX;
         if (link.hdr_id == LCFD_ID_DIAG_REQ) begin
            st_next.frame = LCFD_FRM_DIAG_REQ;
            st_next.csum  = LCFD_RST_BYTE;      // Classic checksum excludes the id
            st_next.pend  = LCFD_RESP_NONE;     // A new request replaces a stale one
         end else if (link.hdr_id == LCFD_ID_DIAG_RESP) begin
            st_next.frame   = LCFD_FRM_DIAG_RESP;
            st_next.sending = st_reg.pend;
            st_next.pend    = LCFD_RESP_NONE;
            st_next.tx_csum = LCFD_RST_BYTE;
         end else begin
            if (link.hdr_id == i_param_frame_id)
               st_next.frame = LCFD_FRM_PARAM;
            else if (link.hdr_id == i_addr_sc_frame_id)
               st_next.frame = LCFD_FRM_ADDR_SC;
            else if (link.hdr_id == i_unaddr_sc_frame_id)
               st_next.frame = LCFD_FRM_UNADDR_SC;
            else
               st_next.frame = LCFD_FRM_NONE;
            st_next.csum  = link.hdr_id;        // Enhanced checksum seeds with the id
         end
      end else if (st_reg.frame == LCFD_FRM_DIAG_RESP) begin
         // Publish one answer byte per cycle, then the classic checksum
         if (st_reg.sending != LCFD_RESP_NONE) begin
            st_next.s_valid = 1'b1;
            st_next.tx_idx  = st_reg.tx_idx + 4'h1;
            if (st_reg.tx_idx == LCFD_LEN_DIAG) begin
               st_next.s_byte  = ~st_reg.tx_csum;
               st_next.sending = LCFD_RESP_NONE;
               st_next.frame   = LCFD_FRM_NONE;
            end else begin
               st_next.s_byte  = lcfd_tx(st_reg.sending, st_reg.tx_idx, i_node_addr);
               st_next.tx_csum = lcfd_csum_add(st_reg.tx_csum, st_next.s_byte);
            end
         end
      end else if (link.m_valid && st_reg.frame != LCFD_FRM_NONE) begin
         // Capture bytes by position within the frame
         st_next.idx = st_reg.idx + 4'h1;
         if (st_reg.idx == lcfd_len(st_reg.frame)) begin
            st_next.csum_ok = (~st_reg.csum == link.m_byte);
         end else begin
            st_next.csum = lcfd_csum_add(st_reg.csum, link.m_byte);
            unique case (st_reg.frame)
               LCFD_FRM_PARAM, LCFD_FRM_ADDR_SC: begin
                  if (st_reg.idx == 4'h0) st_next.nad = link.m_byte;
                  else if (st_reg.idx == 4'h1) st_next.cmd = link.m_byte;
                  else st_next.data = {link.m_byte, st_reg.data[39:8]};
               end
               LCFD_FRM_UNADDR_SC: st_next.cmd = link.m_byte;
               default: begin
                  unique case (st_reg.idx)
                     4'h0:    st_next.nad = link.m_byte;
                     4'h1:    st_next.cmd = link.m_byte;   // Protocol control byte
                     4'h2:    st_next.sel = link.m_byte;   // Service byte held in sel briefly
                     4'h3:    st_next.sel = (st_reg.sel == LCFD_SID_READ_ID) ?
                                            link.m_byte : LCFD_FILL;
                     default: st_next.ids = {link.m_byte, st_reg.ids[31:8]};
                  endcase
               end
            endcase
         end
      end else if (link.eof && st_reg.frame != LCFD_FRM_NONE) begin
         // Frame complete: act only when every byte arrived and checksum held
         addr_ok = (st_reg.nad == i_node_addr) || (st_reg.nad == LCFD_NAD_BROADCAST);
         op      = lcfd_decode(st_reg.frame, st_reg.cmd);
         id_ok   = (st_reg.ids[15:0] == SUPPLIER_CODE || st_reg.ids[15:0] == LCFD_SUPPLIER_WILD)
                && (st_reg.ids[31:16] == FUNCTION_CODE
                    || st_reg.ids[31:16] == LCFD_FUNCTION_WILD);
         if (st_reg.idx == lcfd_len(st_reg.frame) + 4'h1 && st_reg.csum_ok) begin
            if (st_reg.frame == LCFD_FRM_DIAG_REQ) begin
               if (addr_ok && id_ok && st_reg.cmd == LCFD_PCI_REQ
                   && st_reg.sel != LCFD_FILL) begin
                  st_next.pend = (st_reg.sel == LCFD_SEL_PRODUCT) ?
                                 LCFD_RESP_POS : LCFD_RESP_NEG;
               end
            end else if (op != LCFD_OP_NONE
                         && (addr_ok || st_reg.frame == LCFD_FRM_UNADDR_SC)) begin
               st_next.cmd_valid = 1'b1;
               st_next.cmd_op    = op;
               st_next.cmd_data  = (st_reg.frame == LCFD_FRM_PARAM) ? st_reg.data : {40{1'b1}};
               st_next.cmd_bc    = (st_reg.frame == LCFD_FRM_UNADDR_SC)
                                || (st_reg.nad == LCFD_NAD_BROADCAST);
            end
         end
         st_next.frame   = LCFD_FRM_NONE;
         st_next.csum_ok = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_cmd_valid     = st_reg.cmd_valid;
   assign o_cmd_op        = st_reg.cmd_op;
   assign o_cmd_data      = st_reg.cmd_data;
   assign o_cmd_broadcast = st_reg.cmd_bc;
   assign link.s_byte     = st_reg.s_byte;
   assign link.s_valid    = st_reg.s_valid;
endmodule : lcfd_node
`default_nettype wire

// [verilog/lcfd_master.sv]
`timescale 1ns/10ps
`default_nettype none
// Master side: frames one request byte-by-byte and collects response bytes
module lcfd_master
   import lcfd_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   // Frame request
   input  wire logic        i_req_valid,
   input  wire logic [7:0]  i_req_id,
   input  wire logic [3:0]  i_req_len,    // Master data bytes, 0 for reading frame
   input  wire logic [63:0] i_req_data,   // Byte 0 first in [7:0]
   input  wire logic        i_req_classic,
   output logic             o_req_ready,
   // Reading frame result
   output logic             o_resp_valid,
   output logic [63:0]      o_resp_data,
   output logic [7:0]       o_resp_csum,
   output logic [3:0]       o_resp_count,
   // Link
   lcfd_link_if.master      link
);
   typedef enum logic [2:0] {
      LCFD_M_IDLE, LCFD_M_DATA, LCFD_M_CSUM, LCFD_M_EOF, LCFD_M_READ
   } lcfd_mstate_type;

   typedef struct packed {
      lcfd_mstate_type st;
      logic [7:0]      id;
      logic [3:0]      len;
      logic [63:0]     data;
      logic [3:0]      idx;
      logic [7:0]      csum;
      logic [4:0]      wait_cnt;
      logic            hdr_valid;
      logic [7:0]      m_byte;
      logic            m_valid;
      logic            eof;
      logic            resp_valid;
      logic [63:0]     resp;
      logic [7:0]      resp_csum;
      logic [3:0]      resp_cnt;
   } lcfd_mst_type;

   lcfd_mst_type m_reg;
   lcfd_mst_type m_next;

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencer
   always_comb begin
      m_next = m_reg;
      m_next.hdr_valid  = 1'b0;
      m_next.m_valid    = 1'b0;
      m_next.eof        = 1'b0;
      m_next.resp_valid = 1'b0;
      unique case (m_reg.st)
         LCFD_M_IDLE: begin
            if (i_req_valid) begin
               m_next.hdr_valid = 1'b1;
               m_next.id        = i_req_id;
               m_next.len       = i_req_len;
               m_next.data      = i_req_data;
               m_next.idx       = 4'h0;
               m_next.csum      = i_req_classic ? LCFD_RST_BYTE : i_req_id;
               m_next.resp_cnt  = 4'h0;
               m_next.wait_cnt  = 5'h00;
               m_next.st        = (i_req_len == 4'h0) ? LCFD_M_READ : LCFD_M_DATA;
            end
         end
         LCFD_M_DATA: begin
            m_next.m_valid = 1'b1;
            m_next.m_byte  = m_reg.data[7:0];
            m_next.csum    = lcfd_csum_add(m_reg.csum, m_reg.data[7:0]);
            m_next.data    = {8'h00, m_reg.data[63:8]};
            m_next.idx     = m_reg.idx + 4'h1;
            if (m_reg.idx + 4'h1 == m_reg.len) m_next.st = LCFD_M_CSUM;
         end
         LCFD_M_CSUM: begin
            m_next.m_valid = 1'b1;
            m_next.m_byte  = ~m_reg.csum;
            m_next.st      = LCFD_M_EOF;
         end
         // End of frame one cycle later, so the node has taken the checksum
         LCFD_M_EOF: begin
            m_next.eof = 1'b1;
            m_next.st  = LCFD_M_IDLE;
         end
         LCFD_M_READ: begin
            // Gather node bytes; a silent node ends the frame after a timeout
            m_next.wait_cnt = m_reg.wait_cnt + 5'h01;
            if (link.s_valid) begin
               m_next.resp     = {link.s_byte, m_reg.resp[63:8]};
               m_next.resp_cnt = m_reg.resp_cnt + 4'h1;
               m_next.resp_csum = link.s_byte;
            end
            if ((link.s_valid && m_reg.resp_cnt == LCFD_LEN_DIAG)
                || m_reg.wait_cnt == LCFD_READ_WAIT) begin
               m_next.eof        = 1'b1;
               m_next.resp_valid = 1'b1;
               m_next.st         = LCFD_M_IDLE;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         m_reg <= '0;
      end else begin
         m_reg <= m_next;
      end
   end

   assign o_req_ready    = (m_reg.st == LCFD_M_IDLE);
   assign o_resp_valid   = m_reg.resp_valid;
   assign o_resp_data    = m_reg.resp;
   assign o_resp_csum    = m_reg.resp_csum;
   assign o_resp_count   = m_reg.resp_cnt;
   assign link.hdr_id    = m_reg.id;
   assign link.hdr_valid = m_reg.hdr_valid;
   assign link.m_byte    = m_reg.m_byte;
   assign link.m_valid   = m_reg.m_valid;
   assign link.eof       = m_reg.eof;
endmodule : lcfd_master
`default_nettype wire

// [bench/lcfd_link_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module lcfd_link_assertions
   import lcfd_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   // Link signals
   input  wire logic [7:0] hdr_id,
   input  wire logic       hdr_valid,
   input  wire logic [7:0] m_byte,
   input  wire logic       m_valid,
   input  wire logic [7:0] s_byte,
   input  wire logic       s_valid,
   input  wire logic       eof
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   logic [3:0] cnt_reg;
   logic [7:0] sum_reg;
   logic [8:0] add;
   ////////////////////////////////////////////////////////////////////////////////
   // Running carry-folded sum of answer bytes; cleared after each checksum byte
   assign add = {1'b0, sum_reg} + {1'b0, s_byte};
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg <= 4'h0;
         sum_reg <= 8'h00;
      end else if (s_valid) begin
         cnt_reg <= (cnt_reg == 4'h8) ? 4'h0 : cnt_reg + 4'h1;
         sum_reg <= (cnt_reg == 4'h8) ? 8'h00 : add[7:0] + {7'h00, add[8]};
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   AST_ANSWER_AFTER_HDR: assert property (
      $rose(s_valid) |-> $past(hdr_valid, 2) && $past(hdr_id, 2) == LCFD_ID_DIAG_RESP)
      else $error("answer without reading header");
   AST_ANSWER_LEN: assert property (
      $rose(s_valid) |-> s_valid[*8] ##1 s_valid ##1 !s_valid)
      else $error("answer not nine bytes");
   AST_ANSWER_PCI: assert property (
      $rose(s_valid) |=> s_byte == LCFD_PCI_POS || s_byte == LCFD_PCI_NEG)
      else $error("bad control byte");
   AST_POS_RSID: assert property (
      $rose(s_valid) ##1 s_byte == LCFD_PCI_POS |=> s_byte == LCFD_RSID_READ_ID)
      else $error("bad positive service byte");
   AST_NEG_BODY: assert property (
      $rose(s_valid) ##1 s_byte == LCFD_PCI_NEG |=> s_byte == LCFD_RSID_NEG
      ##1 s_byte == LCFD_SID_READ_ID ##1 s_byte == LCFD_ERR_SUBFUNC
      ##1 s_byte == LCFD_FILL ##1 s_byte == LCFD_FILL ##1 s_byte == LCFD_FILL)
      else $error("bad negative answer body");
   AST_ANSWER_CSUM: assert property (
      s_valid && cnt_reg == 4'h8 |-> s_byte == ~sum_reg)
      else $error("bad answer checksum");
   AST_NOT_IN_REQUEST: assert property (s_valid |-> !m_valid)
      else $error("answer overlaps master byte");
   AST_HDR_QUIET: assert property (hdr_valid |-> !s_valid && !m_valid && !eof)
      else $error("header during frame traffic");
endmodule : lcfd_link_assertions
`default_nettype wire

// [bench/test_lin_command_frame_decoder.sv]
`timescale 1ns/10ps
`default_nettype none
module test_lin_command_frame_decoder;
   import lcfd_pkg::*;
   localparam logic [7:0]  NAD = 8'h15;
   localparam logic [15:0] SUP = 16'h0a5a;  // Arbitrary, as set in the node
   localparam logic [15:0] FUN = 16'h0b6b;  // Arbitrary, as set in the node
   localparam logic [7:0]  VAR = 8'h01;     // Arbitrary, as set in the node
   logic        i_clk_sys = 1'b0;
   logic        i_rst_n   = 1'b0;
   logic        rv        = 1'b0;
   logic [7:0]  rid       = 8'h00;
   logic [3:0]  rlen      = 4'h0;
   logic [63:0] rdat      = 64'h0;
   logic        rcl       = 1'b0;
   logic        rdy, resp_v, cmd_v, cmd_bc;
   logic [7:0]  resp_cs;
   logic [3:0]  resp_n, rcnt;
   logic [39:0] cmd_d;
   lcfd_op_type cmd_op;
   logic [7:0]  ans[$];
   int          fail_count = 0;
   int          cmp_count = 0;
   int          ncmd = 0;
   int          cycles = 0;
   lcfd_link_if link ();
   lcfd_master u_lcfd_master (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req_valid(rv),
      .i_req_id(rid), .i_req_len(rlen), .i_req_data(rdat), .i_req_classic(rcl),
      .o_req_ready(rdy), .o_resp_valid(resp_v), .o_resp_data(), .o_resp_csum(resp_cs),
      .o_resp_count(resp_n), .link(link));
   lcfd_node u_lcfd_node (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_node_addr(NAD),
      .i_param_frame_id(8'h20), .i_addr_sc_frame_id(8'h21), .i_unaddr_sc_frame_id(8'h22),
      .o_cmd_valid(cmd_v), .o_cmd_op(cmd_op), .o_cmd_data(cmd_d), .o_cmd_broadcast(cmd_bc),
      .link(link));
   lcfd_link_assertions u_lcfd_link_assertions (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
      .hdr_id(link.hdr_id), .hdr_valid(link.hdr_valid), .m_byte(link.m_byte),
      .m_valid(link.m_valid), .s_byte(link.s_byte), .s_valid(link.s_valid), .eof(link.eof));
   ////////////////////////////////////////////////////////////////////////////////
   always #2 i_clk_sys = ~i_clk_sys;
   // Count commands, log answer bytes, cut a hang short
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cmd_v === 1'b1) ncmd <= ncmd + 1;
      if (link.s_valid === 1'b1) ans.push_back(link.s_byte);
      if (resp_v === 1'b1) rcnt <= resp_n;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Carry-folded sum, inverted; hand-rolled so it is independent of the design
   function automatic logic [7:0] csum(input logic [63:0] d);
      logic [8:0] s;
      logic [7:0] a;
      a = 8'h00;
      for (int i = 0; i < 8; i++) begin
         s = {1'b0, a} + {1'b0, d[8*i +: 8]};
         a = s[7:0] + {7'h00, s[8]};
      end
      return ~a;
   endfunction : csum
   // One master frame; waits until the master is idle again
   task automatic send(input logic [7:0] id, input logic [3:0] len, input logic [63:0] d,
                       input logic cl);
      int n;
      n = 0;
      #1;
      rid = id;
      rlen = len;
      rdat = d;
      rcl = cl;
      rv = 1'b1;
      @(posedge i_clk_sys);  // Ready is high while idle, so taken here
      #1 rv = 1'b0;
      while (rdy !== 1'b1 && n < 200) begin
         @(posedge i_clk_sys);
         #1 n++;
      end
      chk(64'(rdy), 64'h1);
      repeat (4) @(posedge i_clk_sys);
   endtask : send
   task automatic wr(input logic [7:0] id, input logic [3:0] len, input logic [63:0] d,
                     input lcfd_op_type op, input logic [39:0] dat, input logic bc, input int hit);
      int n0;
      n0 = ncmd;
      send(id, len, d, 1'b0);
      chk(64'(ncmd - n0), 64'(hit));
      if (hit == 1) begin
         chk(64'(cmd_op), 64'(op));
         chk(64'(cmd_d), 64'(dat));
         chk(64'(cmd_bc), 64'(bc));
      end
   endtask : wr
   // Reading frame; n is 9 for an answer, 0 for silence
   task automatic rd(input logic [63:0] exp, input int n);
      ans.delete();
      send(LCFD_ID_DIAG_RESP, 4'h0, 64'h0, 1'b1);
      chk(64'(ans.size()), 64'(n));
      chk(64'(rcnt), 64'(n));
      if (n == 9) chk(64'(resp_cs), 64'(csum(exp)));
      for (int i = 0; i < n; i++)
         chk(64'(ans[i]), i < 8 ? 64'(exp[8*i +: 8]) : 64'(csum(exp)));
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge i_clk_sys);
      #1 i_rst_n = 1'b1;
      @(posedge i_clk_sys);
      for (int i = 0; i < 5; i++) begin
         wr(8'h20, 4'h7, {40'hffff3322a5, 8'(i == 0 ? 8'h08 : i == 1 ? 8'h09 : i == 2 ? 8'h10 :
            i == 3 ? 8'h16 : 8'h2f), NAD}, lcfd_op_type'(4'(i + 1)), 40'hffff3322a5, 1'b0, 1);
      end
      wr(8'h20, 4'h7, {40'hffffffff11, 8'h09, 8'h7f}, LCFD_OP_MOTOR_PARAMETER_WRITE,
         40'hffffffff11, 1'b1, 1);
      wr(8'h20, 4'h7, {40'hffffffff11, 8'h09, 8'h16}, LCFD_OP_NONE, 40'h0, 1'b0, 0);
      wr(8'h20, 4'h7, {40'hffffffff11, 8'h04, NAD}, LCFD_OP_NONE, 40'h0, 1'b0, 0);
      for (int i = 0; i < 4; i++) begin
         wr(8'h21, 4'h2, {48'h0, 8'(i == 3 ? 8'h0f : 8'(i + 4)), NAD},
            lcfd_op_type'(4'(i + 6)), 40'hffffffffff, 1'b0, 1);
         wr(8'h22, 4'h1, {56'h0, 8'(i == 3 ? 8'h0f : 8'(i + 4))},
            lcfd_op_type'(4'(i + 6)), 40'hffffffffff, 1'b1, 1);
      end
      wr(8'h22, 4'h1, {56'h0, 8'h08}, LCFD_OP_NONE, 40'h0, 1'b0, 0);
      send(8'h3c, 4'h8, {16'hffff, 16'h7fff, 8'h00, 8'hb2, 8'h06, NAD}, 1'b1);
      rd({VAR, FUN, SUP, 8'hf2, 8'h06, NAD}, 9);
      rd(64'h0, 0);
      send(8'h3c, 4'h8, {FUN, SUP, 8'h01, 8'hb2, 8'h06, NAD}, 1'b1);
      rd({24'hffffff, 8'h12, 8'hb2, 8'h7f, 8'h03, NAD}, 9);
      send(8'h3c, 4'h8, {FUN, 16'h1234, 8'h00, 8'hb2, 8'h06, NAD}, 1'b1);
      rd(64'h0, 0);
      give_verdict();
   end
endmodule : test_lin_command_frame_decoder
`default_nettype wire
